// *** hdl/bsc_exec.sv ***
// bsc_exec: executes bit-test-skip, watchdog kick, call, invert, decrement and clears
// assumes file register data (i_fdata) arrives combinationally for the o_faddr-indexed read
// assumes the watchdog, its prescaler and the return stack sit outside and act on
// the one-cycle pulses o_wdt_clear and o_push
// Overview of operation
// - bit set: discard next, nop, two cycles
// - bit clear: next executes, no flags changed
// - watchdog kick zeroes the watchdog counter
// - watchdog kick also zeroes its prescaler
// - watchdog kick sets time-expired and sleep flags
// - call pushes pc plus one onto stack
// - call loads eleven-bit literal into pc[10:0]
// - call takes pc[12:11] from latch bits 4:3
// - call takes two cycles, flags untouched
// - invert complements file, affects only zero flag
// - dest 0 writes accumulator, 1 writes file
// - decrement file, selected destination, zero flag only
// - clear file writes zero, sets zero flag
// - clear accumulator, sets zero flag
`timescale 1ns/1ns
`default_nettype none
module bsc_exec
  import bsc_pkg::*;
(
  input wire logic i_clk,                       // 125 MHz instruction clock
  input wire logic i_rst_n,                     // async active-low reset
  input wire logic i_insn_valid,                // instruction word present
  input wire logic [INSN_W-1:0] i_insn,         // instruction word
  input wire logic [DATA_W-1:0] i_fdata,        // addressed file register value
  input wire logic [DATA_W-1:0] i_upper_pc_latch, // upper pc latch register
  output logic [FADDR_W-1:0] o_faddr,           // file address being read
  output logic o_fwrite,                        // file write strobe
  output logic [FADDR_W-1:0] o_fwaddr,          // file write address
  output logic [DATA_W-1:0] o_fwdata,           // file write data
  output logic [DATA_W-1:0] o_acc,              // accumulator
  output logic [PC_W-1:0] o_pc,                 // program counter
  output logic o_push,                          // stack push pulse
  output logic [PC_W-1:0] o_stack_head,         // value pushed to stack
  output logic o_zero_flag,                     // result-null flag
  output logic o_time_expired_flag,             // time-expired status
  output logic o_sleep_flag,                    // sleep status
  output logic o_wdt_clear,                     // watchdog counter and prescaler clear pulse
  output logic o_busy                           // high while the second cycle is a nop
);
  // reset leaves through two flops so every register below sees a clean
  // release on a clock edge; assertion stays asynchronous
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  bsc_state_t state_q, state_d;
  logic exec;
  assign exec = i_insn_valid && (state_q == BSC_EXEC);
  assign o_faddr = i_insn[FADDR_W-1:0];
  assign o_busy = (state_q == BSC_FLUSH);

  // decode: word matches are kept apart from the issue gate, so a word that
  // arrives in the flush slot matches but never reaches any state
  logic hit_kick, hit_acc_zero, hit_zero_file, hit_minus_one, hit_invert, hit_skip, hit_call;
  assign hit_kick = (i_insn == OP_KICK_WATCHDOG);
  assign hit_acc_zero = (i_insn == OP_ACC_ZERO);
  assign hit_zero_file = (i_insn[13:7] == OPH_ZERO_FILE);
  assign hit_minus_one = (i_insn[13:8] == OPH_MINUS_ONE);
  assign hit_invert = (i_insn[13:8] == OPH_INVERT);
  assign hit_skip = (i_insn[13:10] == OPH_TEST_SKIP_ONE);
  assign hit_call = (i_insn[13:11] == OPH_CALL);

  // words outside this group only advance the pc
  logic is_kick, is_acc_zero, is_zero_file, is_minus_one, is_invert, is_skip, is_call;
  assign is_kick = exec && hit_kick;
  assign is_acc_zero = exec && hit_acc_zero;
  assign is_zero_file = exec && hit_zero_file;
  assign is_minus_one = exec && hit_minus_one;
  assign is_invert = exec && hit_invert;
  assign is_skip = exec && hit_skip;
  assign is_call = exec && hit_call;

  logic [2:0] bitsel;
  logic skip_taken, dest_file;
  logic [DATA_W-1:0] result;
  logic has_result;
  assign bitsel = i_insn[BITSEL_LSB+2:BITSEL_LSB];
  // one-hot bit picker: each lane compares its own index, no variable shifter
  logic [DATA_W-1:0] bit_hit;
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_bit_pick
      assign bit_hit[gi] = i_fdata[gi] && (bitsel == 3'(gi));
    end
  endgenerate
  assign skip_taken = is_skip && (|bit_hit);
  assign dest_file = i_insn[DEST_BIT];

  // only invert and decrement compute; clears take constants directly
  always_comb begin
    result = ZERO_BYTE;
    has_result = 1'b0;
    if (is_invert) begin
      result = ~i_fdata;
      has_result = 1'b1;
    end else if (is_minus_one) begin
      result = i_fdata - 8'h01;
      has_result = 1'b1;
    end
  end

  // two-cycle ops flush the following slot with a nop
  always_comb begin
    state_d = BSC_EXEC;
    case (state_q)
      BSC_EXEC: state_d = (skip_taken || is_call) ? BSC_FLUSH : BSC_EXEC;
      BSC_FLUSH: state_d = BSC_EXEC;
      default: state_d = BSC_EXEC;
    endcase
  end
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) state_q <= BSC_EXEC;
    else state_q <= state_d;
  end

  // program counter: the flush slot advances it too, so a taken skip lands
  // two words on; a call's own flush steps past the target by one
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_pc <= PC_RESET;
    end else begin
      if (is_call) begin
        o_pc <= {i_upper_pc_latch[LATCH_HI:LATCH_LO], i_insn[LIT_W-1:0]};
      end else if (exec || state_q == BSC_FLUSH) begin
        o_pc <= o_pc + 13'h0001; // skipped slot still advances pc
      end
    end
  end

  // return address and push pulse; the stack itself is outside
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_push <= 1'b0;
      o_stack_head <= PC_RESET;
    end else begin
      o_push <= is_call;
      if (is_call) begin
        o_stack_head <= o_pc + 13'h0001;
      end
    end
  end

  // accumulator
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_acc <= ACC_RESET;
    end else begin
      if (is_acc_zero) o_acc <= ZERO_BYTE;
      else if (has_result && !dest_file) o_acc <= result;
    end
  end

  // file write port: address and data follow every word, the strobe qualifies
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_fwrite <= 1'b0;
      o_fwaddr <= '0;
      o_fwdata <= ZERO_BYTE;
    end else begin
      o_fwrite <= (has_result && dest_file) || is_zero_file;
      o_fwaddr <= i_insn[FADDR_W-1:0];
      o_fwdata <= is_zero_file ? ZERO_BYTE : result;
    end
  end

  // watchdog clear pulse; counter and prescaler zero on it outside
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_wdt_clear <= 1'b0;
    end else begin
      o_wdt_clear <= is_kick;
    end
  end

  // time-expired and sleep: only the kick touches them here; the events
  // that clear them belong to the watchdog and sleep logic outside
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_time_expired_flag <= 1'b1;
      o_sleep_flag <= 1'b1;
    end else begin
      if (is_kick) begin
        o_time_expired_flag <= 1'b1;
        o_sleep_flag <= 1'b1;
      end
    end
  end

  // zero flag; call, skip and kick leave it alone
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_zero_flag <= 1'b0;
    end else begin
      if (is_zero_file || is_acc_zero) o_zero_flag <= 1'b1;
      else if (has_result) o_zero_flag <= (result == ZERO_BYTE);
    end
  end
endmodule : bsc_exec
`default_nettype wire

// *** shared/bsc_pkg.sv ***
// bsc_pkg: opcodes, field layout and reset values for the bit-skip/clear/call executor
// assumes a 14-bit instruction word with 7-bit file address and 13-bit program counter
package bsc_pkg;
  localparam int unsigned INSN_W = 14;
  localparam int unsigned PC_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned LIT_W = 11;
  // instruction encodings (14-bit)
  localparam logic [INSN_W-1:0] OP_KICK_WATCHDOG = 14'h0064;
  localparam logic [INSN_W-1:0] OP_ACC_ZERO = 14'h0103;
  localparam logic [6:0] OPH_ZERO_FILE = 7'h03;     // insn[13:7]
  localparam logic [5:0] OPH_MINUS_ONE = 6'h03;     // insn[13:8]
  localparam logic [5:0] OPH_INVERT = 6'h09;        // insn[13:8]
  localparam logic [3:0] OPH_TEST_SKIP_ONE = 4'h7;  // insn[13:10]
  localparam logic [2:0] OPH_CALL = 3'h4;           // insn[13:11]
  // field positions
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned BITSEL_LSB = 7;
  localparam int unsigned LATCH_HI = 4;
  localparam int unsigned LATCH_LO = 3;
  // reset values
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  typedef enum logic [0:0] {
    BSC_EXEC = 1'b0,
    BSC_FLUSH = 1'b1
  } bsc_state_t;
endpackage : bsc_pkg

// *** tb/bsc_exec_checker.sv ***
// bsc_exec_checker: port assertions for bsc_exec
// assumes it is bound onto bsc_exec from the bench top
`timescale 1ns/1ns
`default_nettype none
module bsc_exec_checker
  import bsc_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // reset pin
  input wire logic i_insn_valid, // word present
  input wire logic o_fwrite, // file strobe
  input wire logic o_push, // push pulse
  input wire logic o_zero_flag, // zero flag
  input wire logic o_time_expired_flag, // time-expired
  input wire logic o_sleep_flag, // sleep
  input wire logic o_wdt_clear, // watchdog clear
  input wire logic o_busy, // flush slot
  input wire logic [INSN_W-1:0] i_insn, // instruction
  input wire logic [DATA_W-1:0] i_fdata, // file value
  input wire logic [DATA_W-1:0] i_upper_pc_latch, // pc latch
  input wire logic [DATA_W-1:0] o_fwdata, // file data
  input wire logic [DATA_W-1:0] o_acc, // accumulator
  input wire logic [PC_W-1:0] o_pc, // program counter
  input wire logic [PC_W-1:0] o_stack_head // return address
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic go;
  assign go = i_insn_valid && !o_busy;
  sequence s_flush;
    o_busy ##1 !o_busy;
  endsequence
  sequence s_call_quiet;
    o_busy && $stable(o_zero_flag) && $stable(o_time_expired_flag) && $stable(o_sleep_flag) ##1 !o_busy;
  endsequence
  a_kick_wdt: assert property (go && i_insn == OP_KICK_WATCHDOG |=> o_wdt_clear && o_time_expired_flag && o_sleep_flag)
    else $error("kick effects missing");
  a_skip_set: assert property (go && i_insn[13:10] == OPH_TEST_SKIP_ONE && i_fdata[i_insn[9:7]] |=> s_flush)
    else $error("skip not taken");
  a_skip_clear: assert property (go && i_insn[13:10] == OPH_TEST_SKIP_ONE && !i_fdata[i_insn[9:7]] |=> !o_busy && $stable(o_zero_flag))
    else $error("skip wrongly taken");
  a_call_target: assert property (go && i_insn[13:11] == OPH_CALL |=> o_push && o_stack_head == $past(o_pc) + 13'h1 && o_pc == {$past(i_upper_pc_latch[4:3]), $past(i_insn[10:0])})
    else $error("call target wrong");
  a_call_two: assert property (go && i_insn[13:11] == OPH_CALL |=> s_call_quiet)
    else $error("call timing wrong");
  a_zero_file: assert property (go && i_insn[13:7] == OPH_ZERO_FILE |=> o_fwrite && o_fwdata == ZERO_BYTE && o_zero_flag)
    else $error("file clear wrong");
  a_acc_zero: assert property (go && i_insn == OP_ACC_ZERO |=> o_acc == 8'h00 && o_zero_flag)
    else $error("acc clear wrong");
  a_minus_file: assert property (go && i_insn[13:7] == {OPH_MINUS_ONE, 1'b1} |=> o_fwrite && o_fwdata == $past(i_fdata) - 8'h01 && o_zero_flag == ($past(i_fdata) == 8'h01))
    else $error("decrement wrong");
  a_invert_acc: assert property (go && i_insn[13:7] == {OPH_INVERT, 1'b0} |=> !o_fwrite && o_acc == ~$past(i_fdata))
    else $error("invert wrong");
  a_one_cycle: assert property (go && (i_insn == OP_KICK_WATCHDOG || i_insn == OP_ACC_ZERO || i_insn[13:7] == OPH_ZERO_FILE || i_insn[13:8] == OPH_MINUS_ONE || i_insn[13:8] == OPH_INVERT) |=> !o_busy)
    else $error("single-cycle op stalled");
endmodule : bsc_exec_checker
`default_nettype wire

// *** tb/bsc_exec_test.sv ***
// bsc_exec_test: table-driven bench for bsc_exec
// assumes bsc_pkg and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module bsc_exec_test;
  import bsc_pkg::*;
  logic i_clk = 0, i_rst_n = 0, i_insn_valid = 0;
  logic [INSN_W-1:0] i_insn = '0;
  logic [DATA_W-1:0] i_fdata = '0, i_upper_pc_latch = '0, o_fwdata, o_acc;
  logic o_fwrite, o_push, o_zero_flag, o_time_expired_flag, o_sleep_flag, o_wdt_clear, o_busy;
  logic [FADDR_W-1:0] o_faddr, o_fwaddr;
  logic [PC_W-1:0] o_pc, o_stack_head, pc;
  int failures = 0, tests_run = 0, cyc = 0;
  // insn, file value, expected result, expected zero flag
  logic [30:0] rows [6] = '{{14'h0910, 8'h5A, 8'hA5, 1'b0}, {14'h0103, 8'h00, 8'h00, 1'b1},
    {14'h0390, 8'h00, 8'hFF, 1'b0}, {14'h01FF, 8'h3C, 8'h00, 1'b1},
    {14'h0310, 8'h01, 8'h00, 1'b1}, {14'h0990, 8'h0F, 8'hF0, 1'b0}};
  bsc_exec dut_u (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_insn_valid(i_insn_valid),
    .i_insn(i_insn),
    .i_fdata(i_fdata),
    .i_upper_pc_latch(i_upper_pc_latch),
    .o_faddr(o_faddr),
    .o_fwrite(o_fwrite),
    .o_fwaddr(o_fwaddr),
    .o_fwdata(o_fwdata),
    .o_acc(o_acc),
    .o_pc(o_pc),
    .o_push(o_push),
    .o_stack_head(o_stack_head),
    .o_zero_flag(o_zero_flag),
    .o_time_expired_flag(o_time_expired_flag),
    .o_sleep_flag(o_sleep_flag),
    .o_wdt_clear(o_wdt_clear),
    .o_busy(o_busy)
  );
  initial forever #4 i_clk = ~i_clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // valid stays high between calls so it is never toggled twice in one step
  task automatic ex(input logic [INSN_W-1:0] w, input logic [DATA_W-1:0] f);
    i_insn = w;
    i_fdata = f;
    i_insn_valid = 1;
    @(posedge i_clk);
    #1 pc = pc + 13'h1;
  endtask : ex
  task automatic close_out;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 400) begin
      failures++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(posedge i_clk);
    #1 i_rst_n = 1;
    chk({o_time_expired_flag, o_sleep_flag, o_busy, o_acc, o_pc}, {3'b110, ACC_RESET, PC_RESET});
    repeat (2) @(posedge i_clk);
    #1 pc = PC_RESET;
    foreach (rows[i]) begin
      ex(rows[i][30:17], rows[i][16:9]);
      chk({o_busy, o_fwrite, rows[i][24] ? o_fwdata : o_acc, o_zero_flag, o_pc}, {1'b0, rows[i][24], rows[i][8:0], pc});
      chk({o_fwaddr, o_faddr}, {rows[i][23:17], rows[i][23:17]});
    end
    ex(OP_KICK_WATCHDOG, 8'h00);
    chk({o_wdt_clear, o_time_expired_flag, o_sleep_flag, o_zero_flag, o_busy}, 5'b11100);
    ex(14'h1D90, 8'hF7);
    chk({o_busy, o_zero_flag, o_pc}, {2'b00, pc});
    ex(14'h1D90, 8'h08);
    chk({o_busy, o_pc}, {1'b1, pc});
    ex(14'h0910, 8'h5A);
    chk({o_busy, o_acc, o_pc}, {1'b0, 8'h00, pc});
    i_upper_pc_latch = 8'h10;
    ex(14'h2555, 8'h00);
    chk({o_busy, o_push, o_zero_flag, o_stack_head, o_pc}, {3'b110, pc, 13'h1555});
    ex(14'h0910, 8'h5A);
    chk({o_busy, o_push, o_acc, o_pc}, {2'b00, 8'h00, 13'h1556});
    i_insn_valid = 0;
    i_rst_n = 0;
    @(posedge i_clk);
    #1 chk({o_time_expired_flag, o_sleep_flag, o_busy, o_acc, o_pc, o_push, o_wdt_clear}, {3'b110, ACC_RESET, PC_RESET, 2'b00});
    i_rst_n = 1;
    repeat (2) @(posedge i_clk);
    #1 ex(14'h0910, 8'h5A);
    chk({o_busy, o_acc, o_pc}, {1'b0, 8'hA5, 13'h0001});
    i_insn_valid = 0;
    close_out();
  end
endmodule : bsc_exec_test
bind bsc_exec bsc_exec_checker chk_u (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_insn_valid(i_insn_valid),
  .o_fwrite(o_fwrite),
  .o_push(o_push),
  .o_zero_flag(o_zero_flag),
  .o_time_expired_flag(o_time_expired_flag),
  .o_sleep_flag(o_sleep_flag),
  .o_wdt_clear(o_wdt_clear),
  .o_busy(o_busy),
  .i_insn(i_insn),
  .i_fdata(i_fdata),
  .i_upper_pc_latch(i_upper_pc_latch),
  .o_fwdata(o_fwdata),
  .o_acc(o_acc),
  .o_pc(o_pc),
  .o_stack_head(o_stack_head)
);
`default_nettype wire
